// ---- pbt_consts.svh ----
`ifndef PBT_CONSTS_SVH
`define PBT_CONSTS_SVH
// Behaviour
// - map pointer low eight bits forced zero
// - map entry address is pointer plus va top
// - physical address is page plus low 11 bits
// - up to 64 pages of 2K, 128K bytes
// - expanded bit selects per-job map pointers
// - expanded setup fetches job map pointer
// - every page fetch checks read/write access
// - table is 256 by 36, four words each
// - missing count loads the maximum count
// - repeated setups accepted regardless of count
// - channel priority, then peripheral priority
// - check entry valid, read direction and size
// - outbound fetches one or sixteen words
// - deliver, await re-request, check error, idle
// - inbound read, await re-request, store, idle
// - page crossing refetches page through map
// - address plus four written back each access
// - count increments per transfer, zero sets overflow
// - overflowed unit requesting gets end of transfer
// - then serve next highest pending request
// - count is two's complement of transfers
// - central control request beats channel requests

// apb map
`define PBT_TBL_LAST 12'h3FC
`define PBT_SETUP_CTL 12'h400
`define PBT_SETUP_ADDR 12'h404
`define PBT_SETUP_COUNT 12'h408
`define PBT_SETUP_GO 12'h40C
`define PBT_STATUS 12'h410

// entry word 0: control
`define PBT_W0_VALID 31
`define PBT_W0_EXP 30
`define PBT_W0_OVF 29
`define PBT_W0_BLOCK 28
`define PBT_W0_MODE_LO 26
// entry word 3: cached page and map pointer
`define PBT_W3_PGV 31
`define PBT_W3_PRD 30
`define PBT_W3_PWR 29
`define PBT_W3_PAGE_LO 16

// main store map entry access bits
`define PBT_MAP_RD 31
`define PBT_MAP_WR 30

// maximum counts, two's complement of words or blocks
`define PBT_MAX_CNT_WORD 16'h8000
`define PBT_MAX_CNT_BLOCK 16'hF800
`define PBT_BLOCK_LAST 4'hF

// error codes
`define PBT_ERR_INVALID 3'h1
`define PBT_ERR_ACCESS 3'h2
`define PBT_ERR_CHAN 3'h3
`define PBT_ERR_PARITY 3'h4
`endif

// ---- pbt_pkg.sv ----
package pbt_pkg;
	typedef enum logic [1:0] {
		PBT_MODE_READ = 2'h0,
		PBT_MODE_WRITE = 2'h1,
		PBT_MODE_CLEAR = 2'h2
	} pbt_mode_e;

	typedef enum logic [2:0] {
		PBT_CMD_NONE = 3'h0,
		PBT_CMD_READ_REQ = 3'h1,
		PBT_CMD_LOAD = 3'h2,
		PBT_CMD_DELIVER = 3'h3,
		PBT_CMD_FETCH_IN = 3'h4,
		PBT_CMD_READ_DATA = 3'h5,
		PBT_CMD_IDLE = 3'h6,
		PBT_CMD_EOT = 3'h7
	} pbt_cmd_e;

	typedef enum logic [13:0] {
		PBT_S_IDLE = 14'h0001,
		PBT_S_SETUP = 14'h0002,
		PBT_S_XPFETCH = 14'h0004,
		PBT_S_SCAN = 14'h0008,
		PBT_S_ENTRY = 14'h0010,
		PBT_S_EOT = 14'h0020,
		PBT_S_PAGE = 14'h0040,
		PBT_S_MSRD = 14'h0080,
		PBT_S_MSWR = 14'h0100,
		PBT_S_CHLOAD = 14'h0200,
		PBT_S_CHREAD = 14'h0400,
		PBT_S_DELIVER = 14'h0800,
		PBT_S_WAITRE = 14'h1000,
		PBT_S_IDLECH = 14'h2000
	} pbt_state_e;
endpackage

// ---- pbt_engine.sv ----
// Our own choices: register access over APB and the address map.
`include "pbt_consts.svh"

module pbt_engine (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] channel_service_request,
	output logic ch_cmd_valid,
	output pbt_pkg::pbt_cmd_e ch_cmd,
	output logic [1:0] ch_sel,
	output logic [3:0] ch_unit,
	output logic [31:0] ch_wdata,
	input wire logic ch_ack,
	input wire logic [31:0] ch_rdata,
	input wire logic ch_err,
	output logic ms_req,
	output logic ms_we,
	output logic [23:0] ms_addr,
	output logic [31:0] ms_wdata,
	input wire logic ms_ack,
	input wire logic [31:0] ms_rdata,
	output logic cc_error
);
	import pbt_pkg::*;

	// ==========================================================
	// table storage and parity
	function automatic logic [3:0] pbt_par(input logic [31:0] d);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 4; i++) begin
			p[i] = ~^d[8*i +: 8];
		end
		return p;
	endfunction

	logic [35:0] tbl [0:255];

	pbt_state_e st;
	logic [5:0] u;
	logic [31:0] e_ctl;
	logic [31:0] e_va;
	logic [31:0] e_cnt;
	logic [31:0] e_map;
	logic [31:0] dreg;
	logic [3:0] wc;
	logic fin;
	logic setup_pend;
	logic err;
	logic [2:0] err_code;
	logic [5:0] err_unit;
	logic [31:0] setup_ctl;
	logic [16:0] setup_addr;
	logic [15:0] setup_count;

	// ==========================================================
	// decode
	wire [7:0] tbl_base = {u, 2'b00};
	wire [35:0] w0 = tbl[tbl_base];
	wire [35:0] w1 = tbl[tbl_base | 8'h01];
	wire [35:0] w2 = tbl[tbl_base | 8'h02];
	wire [35:0] w3 = tbl[tbl_base | 8'h03];
	wire w0_bad = pbt_par(w0[31:0]) != w0[35:32];
	wire w1_bad = pbt_par(w1[31:0]) != w1[35:32];
	wire w2_bad = pbt_par(w2[31:0]) != w2[35:32];
	wire w3_bad = pbt_par(w3[31:0]) != w3[35:32];
	wire ent_bad = w0_bad | w1_bad | w2_bad | w3_bad;
	wire [1:0] mode = e_ctl[`PBT_W0_MODE_LO +: 2];
	wire outbound = mode != PBT_MODE_WRITE;
	wire is_clear = mode == PBT_MODE_CLEAR;
	wire blk = e_ctl[`PBT_W0_BLOCK];
	wire pgv = e_map[`PBT_W3_PGV];
	wire [12:0] page = e_map[`PBT_W3_PAGE_LO +: 13];
	wire [23:0] map_addr = {e_map[15:0], e_va[16:11], 2'b00};
	wire [23:0] phys = {page, e_va[10:0]};
	wire [23:0] fresh_phys = {ms_rdata[12:0], e_va[10:0]};
	wire acc_ok = outbound ?
		(ms_rdata[`PBT_MAP_RD] & (~is_clear | ms_rdata[`PBT_MAP_WR])) :
		ms_rdata[`PBT_MAP_WR];
	wire [16:0] va_next = e_va[16:0] + 17'h00004;
	wire crossing = va_next[10:0] == 11'h000;
	wire last_word = blk ? (wc == `PBT_BLOCK_LAST) : 1'b1;
	wire [15:0] cnt_next = e_cnt[15:0] + 16'h0001;
	wire [7:0] job = setup_ctl[23:16];
	wire has_count = setup_ctl[9];
	wire [23:0] ptrptr = w0[23:0] + {15'h0000, job[7:1], 2'b00};

	// channel priority, lowest index first
	logic [1:0] pri_chan;
	logic [3:0] pri_unit;
	always_comb begin
		pri_chan = 2'h0;
		pri_unit = 4'h0;
		for (int i = 3; i >= 0; i--) begin
			if (channel_service_request[i]) begin
				pri_chan = 2'(i);
			end
		end
		for (int i = 15; i >= 0; i--) begin
			if (ch_rdata[i]) begin
				pri_unit = 4'(i);
			end
		end
	end

	wire adv_ev = (st == PBT_S_CHLOAD && ch_ack) ||
		(st == PBT_S_MSWR && ms_ack && !outbound);
	wire re_req = channel_service_request[u[5:4]];

	// ==========================================================
	// apb slave
	wire apb_acc = psel && penable;
	wire is_tbl = paddr <= `PBT_TBL_LAST;
	wire is_reg = paddr == `PBT_SETUP_CTL || paddr == `PBT_SETUP_ADDR ||
		paddr == `PBT_SETUP_COUNT || paddr == `PBT_SETUP_GO ||
		paddr == `PBT_STATUS;
	wire tbl_free = st == PBT_S_IDLE;
	assign pready = is_tbl ? tbl_free : 1'b1;
	assign pslverr = apb_acc && !is_tbl && !is_reg;
	wire apb_wr = apb_acc && pwrite && pready && !pslverr;
	wire apb_tbl_wr = apb_wr && is_tbl;
	wire go_wr = apb_wr && paddr == `PBT_SETUP_GO;
	wire clr_err = apb_wr && paddr == `PBT_STATUS && pwdata[1];
	wire [31:0] status = {18'h00000, err_unit, 3'h0, err_code, err,
		!tbl_free};

	always_comb begin
		prdata = 32'h00000000;
		if (is_tbl) begin
			prdata = tbl[paddr[9:2]][31:0];
		end else if (paddr == `PBT_SETUP_CTL) begin
			prdata = setup_ctl;
		end else if (paddr == `PBT_SETUP_ADDR) begin
			prdata = {15'h0000, setup_addr};
		end else if (paddr == `PBT_SETUP_COUNT) begin
			prdata = {16'h0000, setup_count};
		end else if (paddr == `PBT_SETUP_GO) begin
			prdata = {31'h00000000, setup_pend};
		end else if (paddr == `PBT_STATUS) begin
			prdata = status;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			setup_ctl <= 32'h00000000;
			setup_addr <= 17'h00000;
			setup_count <= 16'h0000;
		end else if (apb_wr) begin
			if (paddr == `PBT_SETUP_CTL) setup_ctl <= pwdata;
			if (paddr == `PBT_SETUP_ADDR) setup_addr <= pwdata[16:0];
			if (paddr == `PBT_SETUP_COUNT) setup_count <= pwdata[15:0];
		end
	end

	// ==========================================================
	// table writes: software in idle, engine elsewhere
	always_ff @(posedge clk) begin
		if (apb_tbl_wr) begin
			tbl[paddr[9:2]] <= {pbt_par(pwdata), pwdata};
		end
		if (adv_ev) begin
			tbl[tbl_base | 8'h01] <= {pbt_par({15'h0000, va_next}),
				15'h0000, va_next};
		end
		if ((st == PBT_S_IDLECH && ch_ack) ||
			(st == PBT_S_SETUP && !e_map[`PBT_W3_PGV] && fin) ||
			(st == PBT_S_XPFETCH && ms_ack)) begin
			tbl[tbl_base] <= {pbt_par(e_ctl), e_ctl};
			tbl[tbl_base | 8'h01] <= {pbt_par(e_va), e_va};
			tbl[tbl_base | 8'h02] <= {pbt_par(e_cnt), e_cnt};
			tbl[tbl_base | 8'h03] <= {pbt_par(e_map), e_map};
			if (st == PBT_S_XPFETCH) begin
				tbl[tbl_base | 8'h03] <= {pbt_par({16'h0000,
					job[0] ? ms_rdata[31:16] : ms_rdata[15:0]}),
					16'h0000, job[0] ? ms_rdata[31:16] :
					ms_rdata[15:0]};
			end
			if (st == PBT_S_IDLECH && fin) begin
				tbl[tbl_base] <= {pbt_par(e_ctl | ({31'h0, cnt_next ==
					16'h0000} << `PBT_W0_OVF)), e_ctl | ({31'h0, cnt_next
					== 16'h0000} << `PBT_W0_OVF)};
				tbl[tbl_base | 8'h02] <= {pbt_par({16'h0000, cnt_next}),
					16'h0000, cnt_next};
			end
		end
	end

	// ==========================================================
	// setup request and error flags, set wins over clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			setup_pend <= 1'b0;
		end else begin
			setup_pend <= go_wr | (setup_pend &
				!(st == PBT_S_IDLE));
		end
	end

	logic err_set;
	logic [2:0] err_set_code;
	always_comb begin
		err_set = 1'b0;
		err_set_code = 3'h0;
		if (st == PBT_S_SETUP && !w0[`PBT_W0_VALID] && !fin) begin
			err_set = 1'b1;
			err_set_code = `PBT_ERR_INVALID;
		end else if (st == PBT_S_ENTRY && ent_bad) begin
			err_set = 1'b1;
			err_set_code = `PBT_ERR_PARITY;
		end else if (st == PBT_S_ENTRY && !w0[`PBT_W0_VALID]) begin
			err_set = 1'b1;
			err_set_code = `PBT_ERR_INVALID;
		end else if (st == PBT_S_PAGE && ms_ack && !acc_ok) begin
			err_set = 1'b1;
			err_set_code = `PBT_ERR_ACCESS;
		end else if (st == PBT_S_WAITRE && re_req && outbound && ch_err) begin
			err_set = 1'b1;
			err_set_code = `PBT_ERR_CHAN;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			err <= 1'b0;
			err_code <= 3'h0;
			err_unit <= 6'h00;
		end else if (err_set) begin
			err <= 1'b1;
			err_code <= err_set_code;
			err_unit <= u;
		end else if (clr_err) begin
			err <= 1'b0;
		end
	end
	assign cc_error = err;

	// ==========================================================
	// transfer sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= PBT_S_IDLE;
			u <= 6'h00;
			e_ctl <= 32'h00000000;
			e_va <= 32'h00000000;
			e_cnt <= 32'h00000000;
			e_map <= 32'h00000000;
			dreg <= 32'h00000000;
			ms_addr <= 24'h000000;
			ms_wdata <= 32'h00000000;
			wc <= 4'h0;
			fin <= 1'b0;
		end else begin
			case (st)
			PBT_S_IDLE: begin
				fin <= 1'b0;
				if (setup_pend) begin
					u <= setup_ctl[5:0];
					st <= PBT_S_SETUP;
				end else if (|channel_service_request) begin
					u <= {pri_chan, 4'h0};
					st <= PBT_S_SCAN;
				end
			end
			PBT_S_SETUP: begin
				if (fin) begin
					st <= PBT_S_IDLE;
				end else if (!w0[`PBT_W0_VALID]) begin
					st <= PBT_S_IDLE;
				end else begin
					e_ctl <= {w0[31:30], 1'b0, setup_ctl[8],
						setup_ctl[7:6], w0[25:0]};
					e_va <= {15'h0000, setup_addr};
					e_cnt <= {16'h0000, has_count ? setup_count :
						(setup_ctl[8] ? `PBT_MAX_CNT_BLOCK :
						`PBT_MAX_CNT_WORD)};
					fin <= 1'b1;
					if (w0[`PBT_W0_EXP]) begin
						e_map <= 32'h00000000;
						ms_addr <= ptrptr;
						st <= PBT_S_XPFETCH;
					end else begin
						e_map <= {16'h0000, w0[23:8]};
					end
				end
			end
			PBT_S_XPFETCH: begin
				if (ms_ack) begin
					st <= PBT_S_IDLE;
				end
			end
			PBT_S_SCAN: begin
				if (ch_ack) begin
					if (ch_rdata[15:0] == 16'h0000) begin
						st <= PBT_S_IDLE;
					end else begin
						u[3:0] <= pri_unit;
						st <= PBT_S_ENTRY;
					end
				end
			end
			PBT_S_ENTRY: begin
				e_ctl <= w0[31:0];
				e_va <= w1[31:0];
				e_cnt <= w2[31:0];
				e_map <= w3[31:0];
				wc <= 4'h0;
				if (ent_bad || !w0[`PBT_W0_VALID]) begin
					st <= PBT_S_IDLECH;
				end else if (w0[`PBT_W0_OVF]) begin
					st <= PBT_S_EOT;
				end else if (w0[`PBT_W0_MODE_LO +: 2] == PBT_MODE_WRITE) begin
					st <= PBT_S_DELIVER;
				end else if (!w3[`PBT_W3_PGV]) begin
					ms_addr <= {w3[15:0], w1[16:11], 2'b00};
					st <= PBT_S_PAGE;
				end else begin
					ms_addr <= {w3[28:16], w1[10:0]};
					st <= PBT_S_MSRD;
				end
			end
			PBT_S_EOT: begin
				if (ch_ack) begin
					st <= PBT_S_IDLE;
				end
			end
			PBT_S_PAGE: begin
				if (ms_ack) begin
					e_map[31:16] <= {1'b1, ms_rdata[`PBT_MAP_RD],
						ms_rdata[`PBT_MAP_WR], ms_rdata[12:0]};
					ms_addr <= fresh_phys;
					if (!acc_ok) begin
						fin <= 1'b0;
						st <= PBT_S_IDLECH;
					end else if (outbound) begin
						st <= PBT_S_MSRD;
					end else begin
						st <= PBT_S_MSWR;
					end
				end
			end
			PBT_S_MSRD: begin
				if (ms_ack) begin
					dreg <= ms_rdata;
					ms_wdata <= 32'h00000000;
					st <= is_clear ? PBT_S_MSWR : PBT_S_CHLOAD;
				end
			end
			PBT_S_CHLOAD: st <= PBT_S_CHLOAD;
			PBT_S_MSWR: begin
				if (ms_ack && outbound) begin
					st <= PBT_S_CHLOAD;
				end
			end
			PBT_S_DELIVER: begin
				if (ch_ack) begin
					st <= PBT_S_WAITRE;
				end
			end
			PBT_S_WAITRE: begin
				if (re_req) begin
					if (outbound) begin
						fin <= !ch_err;
						st <= PBT_S_IDLECH;
					end else begin
						st <= PBT_S_CHREAD;
					end
				end
			end
			PBT_S_CHREAD: begin
				if (ch_ack) begin
					ms_wdata <= ch_rdata;
					if (pgv) begin
						ms_addr <= phys;
						st <= PBT_S_MSWR;
					end else begin
						ms_addr <= map_addr;
						st <= PBT_S_PAGE;
					end
				end
			end
			PBT_S_IDLECH: begin
				if (ch_ack) begin
					st <= PBT_S_IDLE;
				end
			end
			default: begin
				st <= PBT_S_IDLE;
			end
			endcase
			if (adv_ev) begin
				e_va <= {15'h0000, va_next};
				wc <= wc + 4'h1;
				if (crossing) begin
					e_map[`PBT_W3_PGV] <= 1'b0;
				end
				if (last_word) begin
					fin <= 1'b1;
					st <= outbound ? PBT_S_DELIVER : PBT_S_IDLECH;
				end else if (!outbound) begin
					st <= PBT_S_CHREAD;
				end else if (crossing || !pgv) begin
					ms_addr <= {e_map[15:0], va_next[16:11], 2'b00};
					st <= PBT_S_PAGE;
				end else begin
					ms_addr <= {page, va_next[10:0]};
					st <= PBT_S_MSRD;
				end
			end
		end
	end

	// ==========================================================
	// outputs toward channels and main store
	assign ch_sel = u[5:4];
	assign ch_unit = u[3:0];
	assign ch_wdata = dreg;
	assign ch_cmd_valid = ch_cmd != PBT_CMD_NONE;
	always_comb begin
		case (st)
		PBT_S_SCAN: ch_cmd = PBT_CMD_READ_REQ;
		PBT_S_EOT: ch_cmd = PBT_CMD_EOT;
		PBT_S_CHLOAD: ch_cmd = PBT_CMD_LOAD;
		PBT_S_DELIVER: ch_cmd = outbound ? PBT_CMD_DELIVER :
			PBT_CMD_FETCH_IN;
		PBT_S_CHREAD: ch_cmd = PBT_CMD_READ_DATA;
		PBT_S_IDLECH: ch_cmd = PBT_CMD_IDLE;
		default: ch_cmd = PBT_CMD_NONE;
		endcase
	end
	assign ms_req = st == PBT_S_XPFETCH || st == PBT_S_PAGE ||
		st == PBT_S_MSRD || st == PBT_S_MSWR;
	assign ms_we = st == PBT_S_MSWR;
endmodule

// ---- pbt_monitor.sv ----
`include "pbt_consts.svh"
// ==========================================
// engine port checks
module pbt_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic [3:0] channel_service_request,
	input wire logic ch_cmd_valid,
	input wire pbt_pkg::pbt_cmd_e ch_cmd,
	input wire logic [1:0] ch_sel,
	input wire logic [3:0] ch_unit,
	input wire logic ch_ack,
	input wire logic ms_req,
	input wire logic [23:0] ms_addr,
	input wire logic ms_ack,
	input wire logic cc_error
);
	timeunit 1ns;
	timeprecision 1ns;
	import pbt_pkg::*;
	pbt_cmd_e last_cmd;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			last_cmd <= PBT_CMD_NONE;
		else if (ch_cmd_valid && ch_ack)
			last_cmd <= ch_cmd;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_cmd_hold: assert property (ch_cmd_valid && !ch_ack |=>
		ch_cmd_valid && $stable(ch_cmd) && $stable(ch_unit) && $stable(ch_sel))
		else $error("channel command changed before ack");
	a_store_hold: assert property (ms_req && !ms_ack |=>
		ms_req && $stable(ms_addr))
		else $error("store request changed before ack");
	a_store_align: assert property (ms_req |-> ms_addr[1:0] == 2'h0)
		else $error("store address not word aligned");
	a_chan_prio: assert property ($rose(ch_cmd_valid) &&
		ch_cmd == PBT_CMD_READ_REQ |-> channel_service_request[ch_sel] &&
		(channel_service_request & ((4'h1 << ch_sel) - 4'h1)) == 4'h0)
		else $error("request register read on wrong channel");
	a_eot_after_rr: assert property (ch_cmd_valid &&
		ch_cmd == PBT_CMD_EOT |-> last_cmd == PBT_CMD_READ_REQ)
		else $error("end of transfer out of order");
	a_deliver_order: assert property (ch_cmd_valid &&
		ch_cmd == PBT_CMD_DELIVER |-> last_cmd == PBT_CMD_LOAD)
		else $error("deliver without loaded data");
	a_fetch_order: assert property (ch_cmd_valid &&
		ch_cmd == PBT_CMD_FETCH_IN |-> last_cmd == PBT_CMD_READ_REQ)
		else $error("inbound read out of order");
	a_error_sticky: assert property (cc_error && !(psel && penable &&
		pwrite && paddr == `PBT_STATUS) |=> cc_error)
		else $error("error flag dropped by itself");
	a_table_wait: assert property (psel && penable &&
		paddr < 12'h400 && (ms_req || ch_cmd_valid) |-> !pready)
		else $error("table access while engine busy");
	c_deliver: cover property (ch_cmd_valid && ch_ack && ch_cmd == PBT_CMD_DELIVER);
	c_fetch: cover property (ch_cmd_valid && ch_ack && ch_cmd == PBT_CMD_FETCH_IN);
	c_eot: cover property (ch_cmd_valid && ch_ack && ch_cmd == PBT_CMD_EOT);
endmodule

// ---- pbt_partner.sv ----
// ==========================================
// selector channels and main store model
module pbt_partner (
	input wire logic clk,
	input wire logic reset,
	input wire logic ch_cmd_valid,
	input wire pbt_pkg::pbt_cmd_e ch_cmd,
	input wire logic [1:0] ch_sel,
	input wire logic [3:0] ch_unit,
	input wire logic [31:0] ch_wdata,
	output logic ch_ack,
	output logic [31:0] ch_rdata,
	output logic ch_err,
	output logic [3:0] channel_service_request,
	input wire logic ms_req,
	input wire logic ms_we,
	input wire logic [23:0] ms_addr,
	input wire logic [31:0] ms_wdata,
	output logic ms_ack,
	output logic [31:0] ms_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import pbt_pkg::*;
	logic [15:0] pend [4];
	logic [3:0] busy, done;
	logic [31:0] mem [8192];
	logic [31:0] outq [$];
	logic [1:0] rrq [$];
	logic [1:0] tsel;
	logic [7:0] cyc;
	int dly, cc, mc, tmr, done_cnt, eot_cnt, in_cnt;
	// line drops while busy, rises again on completion
	always_comb begin
		for (int c = 0; c < 4; c++)
			channel_service_request[c] = (pend[c] != 16'h0 && !busy[c]) || done[c];
	end
	logic err_inj = 1'h0;
	assign ch_err = err_inj;
	assign ch_rdata = !ch_ack ? {4{cyc}} : ch_cmd == PBT_CMD_READ_REQ ?
		{16'h0, pend[ch_sel]} : 32'hB000_0000 + in_cnt;
	assign ms_rdata = ms_ack ? mem[ms_addr[14:2]] : {4{~cyc}};
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ch_ack <= 1'h0;
			ms_ack <= 1'h0;
			busy <= 4'h0;
			done <= 4'h0;
			cc <= 0;
			mc <= 0;
			tmr <= 0;
			cyc <= 8'h0;
			for (int c = 0; c < 4; c++)
				pend[c] <= 16'h0;
		end else begin
			cyc <= cyc + 8'h1;
			ch_ack <= 1'h0;
			ms_ack <= 1'h0;
			if (ch_cmd_valid && !ch_ack)
				if (cc >= dly) begin
					ch_ack <= 1'h1;
					cc <= 0;
				end else
					cc <= cc + 1;
			if (ms_req && !ms_ack)
				if (mc >= dly) begin
					ms_ack <= 1'h1;
					mc <= 0;
				end else
					mc <= mc + 1;
			if (ms_req && ms_ack && ms_we)
				mem[ms_addr[14:2]] <= ms_wdata;
			if (tmr > 0) begin
				tmr <= tmr - 1;
				if (tmr == 1)
					done[tsel] <= 1'h1;
			end
			if (ch_cmd_valid && ch_ack)
				case (ch_cmd)
					PBT_CMD_READ_REQ: rrq.push_back(ch_sel);
					PBT_CMD_LOAD: outq.push_back(ch_wdata);
					PBT_CMD_READ_DATA: in_cnt <= in_cnt + 1;
					PBT_CMD_DELIVER, PBT_CMD_FETCH_IN: begin
						pend[ch_sel][ch_unit] <= 1'h0;
						busy[ch_sel] <= 1'h1;
						tsel <= ch_sel;
						tmr <= 4;
					end
					PBT_CMD_IDLE: begin
						busy[ch_sel] <= 1'h0;
						done[ch_sel] <= 1'h0;
						done_cnt <= done_cnt + 1;
					end
					PBT_CMD_EOT: begin
						pend[ch_sel][ch_unit] <= 1'h0;
						eot_cnt <= eot_cnt + 1;
						done_cnt <= done_cnt + 1;
					end
					default: ;
				endcase
		end
	end
endmodule

// ---- pbt_engine_test.sv ----
`include "pbt_consts.svh"
`define CHK(n, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("unexpected %s exp %h got %h", n, e, g); \
	end \
end
// ==========================================
// engine testbench
module pbt_engine_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pbt_pkg::*;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, ch_wdata, ch_rdata, ms_wdata, ms_rdata;
	logic [3:0] channel_service_request, ch_unit;
	logic [1:0] ch_sel;
	logic ch_cmd_valid, ch_ack, ch_err, ms_req, ms_we, ms_ack, cc_error;
	logic [23:0] ms_addr;
	pbt_cmd_e ch_cmd;
	int cyc, mismatches, checks;
	logic [7:0] sjob = 8'h00;
	pbt_engine uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .channel_service_request, .ch_cmd_valid,
		.ch_cmd, .ch_sel, .ch_unit, .ch_wdata, .ch_ack, .ch_rdata, .ch_err,
		.ms_req, .ms_we, .ms_addr, .ms_wdata, .ms_ack, .ms_rdata, .cc_error);
	pbt_partner pm (.clk, .reset, .ch_cmd_valid, .ch_cmd, .ch_sel, .ch_unit,
		.ch_wdata, .ch_ack, .ch_rdata, .ch_err, .channel_service_request,
		.ms_req, .ms_we, .ms_addr, .ms_wdata, .ms_ack, .ms_rdata);
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			finish_test;
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		r = prdata;
		serr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task setup(input logic [5:0] u, input logic [3:0] f,
		input logic [16:0] va, input logic [15:0] cnt);
		int n;
		apb(1'h1, `PBT_SETUP_CTL, {8'h0, sjob, 6'h0, f, u});
		apb(1'h1, `PBT_SETUP_ADDR, {15'h0, va});
		apb(1'h1, `PBT_SETUP_COUNT, {16'h0, cnt});
		apb(1'h1, `PBT_SETUP_GO, 32'h0);
		n = 0;
		do begin
			apb(1'h0, `PBT_SETUP_GO, 32'h0);
			n++;
		end while (r[0] !== 1'h0 && n < 50);
	endtask
	task wait_done(input int n);
		int k;
		k = 0;
		while (pm.done_cnt < n && k < 3000) begin
			@(posedge clk);
			k++;
		end
		`CHK("job done", 1'h1, pm.done_cnt >= n)
	endtask
	task tdone(input int t);
		$display("test %0d finished", t);
	endtask
	initial begin
		reset = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		pm.dly = 0;
		pm.mem[13'h040] = 32'hC000_0003;
		pm.mem[13'h041] = 32'hC000_0002;
		pm.mem[13'h042] = 32'h0;
		pm.mem[13'h401] = 32'hA5A5_0001;
		// test 1: decode and table words
		apb(1'h1, 12'h034, 32'h1234_5678);
		apb(1'h0, 12'h034, 32'h0);
		`CHK("table word", 32'h1234_5678, r)
		apb(1'h0, 12'h800, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {serr, r})
		apb(1'h0, `PBT_STATUS, 32'h0);
		`CHK("status", 2'h0, r[1:0])
		apb(1'h1, 12'h030, 32'h0);
		for (int i = 0; i < 4; i++)
			apb(1'h1, i == 3 ? 12'h120 : 12'(i * 16), 32'h8000_01FF);
		tdone(1);
		// test 2: outbound word through page map
		setup(6'h00, 4'h8, 17'h00804, 16'hFFFF);
		pm.pend[0][0] = 1'h1;
		wait_done(1);
		`CHK("out word", 32'hA5A5_0001, pm.outq[0])
		apb(1'h0, 12'h004, 32'h0);
		`CHK("address", 32'h0000_0808, r)
		apb(1'h0, 12'h008, 32'h0);
		`CHK("count", 16'h0000, r[15:0])
		apb(1'h0, 12'h000, 32'h0);
		`CHK("overflow", 1'h1, r[29])
		apb(1'h0, 12'h00C, 32'h0);
		`CHK("page", 13'h0002, r[28:16])
		tdone(2);
		// test 3: end of transfer, then fresh setup
		pm.pend[0][0] = 1'h1;
		wait_done(2);
		`CHK("eot count", 1, pm.eot_cnt)
		`CHK("no data", 1, pm.outq.size())
		setup(6'h00, 4'h0, 17'h00804, 16'h0);
		apb(1'h0, 12'h008, 32'h0);
		`CHK("max count", `PBT_MAX_CNT_WORD, r[15:0])
		apb(1'h0, 12'h000, 32'h0);
		`CHK("overflow clear", 1'h0, r[29])
		tdone(3);
		// test 4: two channels, inbound block first
		pm.dly = 2;
		setup(6'h01, 4'h5, 17'h0, 16'h0);
		setup(6'h12, 4'h8, 17'h00804, 16'hFFFF);
		pm.pend[1][2] = 1'h1;
		pm.pend[0][1] = 1'h1;
		apb(1'h0, 12'h034, 32'h0);
		wait_done(4);
		`CHK("first chan", 2'h0, pm.rrq[2])
		`CHK("next chan", 2'h1, pm.rrq[3])
		for (int i = 0; i < 16; i++)
			`CHK("in word", 32'hB000_0000 + i, pm.mem[13'h600 + i])
		apb(1'h0, 12'h018, 32'h0);
		`CHK("block count", `PBT_MAX_CNT_BLOCK + 16'h1, r[15:0])
		apb(1'h0, 12'h014, 32'h0);
		`CHK("block addr", 32'h40, r)
		`CHK("chan1 word", 32'hA5A5_0001, pm.outq[1])
		tdone(4);
		// test 5: no write right on page
		pm.dly = 0;
		setup(6'h02, 4'h9, 17'h01000, 16'hFFFF);
		pm.pend[0][2] = 1'h1;
		wait_done(5);
		`CHK("error line", 1'h1, cc_error)
		apb(1'h0, `PBT_STATUS, 32'h0);
		`CHK("error code", 3'h2, r[4:2])
		apb(1'h0, 12'h028, 32'h0);
		`CHK("count kept", 16'hFFFF, r[15:0])
		apb(1'h1, `PBT_STATUS, 32'h2);
		apb(1'h0, `PBT_STATUS, 32'h0);
		`CHK("error clear", 1'h0, r[1])
		tdone(5);
		// test 6: invalid entry, then expanded unit in read and clear
		setup(6'h03, 4'h8, 17'h0, 16'hFFFF);
		apb(1'h0, `PBT_STATUS, 32'h0);
		`CHK("invalid code", 4'h3, r[4:1])
		apb(1'h1, `PBT_STATUS, 32'h2);
		pm.mem[13'h201] = 32'h0005_0000;
		pm.mem[13'h140] = 32'hC000_0004;
		pm.mem[13'h800] = 32'h5A5A_0006;
		apb(1'h1, 12'h030, 32'hC000_0800);
		sjob = 8'h03;
		setup(6'h03, 4'hA, 17'h0, 16'hFFFF);
		apb(1'h0, 12'h03C, 32'h0);
		`CHK("job map", 16'h0005, r[15:0])
		pm.pend[0][3] <= 1'h1;
		wait_done(6);
		`CHK("exp word", 32'h5A5A_0006, pm.outq[2])
		`CHK("cleared", 32'h0, pm.mem[13'h800])
		tdone(6);
		// test 7: channel error keeps the count
		pm.err_inj <= 1'h1;
		pm.pend[0][0] <= 1'h1;
		wait_done(7);
		pm.err_inj <= 1'h0;
		apb(1'h0, `PBT_STATUS, 32'h0);
		`CHK("chan error", 4'h7, r[4:1])
		apb(1'h0, 12'h008, 32'h0);
		`CHK("count held", 16'h8000, r[15:0])
		tdone(7);
		finish_test;
	end
endmodule
bind pbt_engine pbt_monitor mon (.clk, .reset, .psel, .penable, .pwrite,
	.paddr, .pready, .channel_service_request, .ch_cmd_valid, .ch_cmd,
	.ch_sel, .ch_unit, .ch_ack, .ms_req, .ms_addr, .ms_ack, .cc_error);
